/* File: logic/ddrrf_core.sv */
/*
  refresh and self-refresh control inside the memory device: decodes the
  refresh and self-refresh entry commands, runs the internal row counter,
  times the refresh cycle, and runs the self-refresh timer while asleep.
  assumes command pins are synchronous to i_clk; the controller keeps its own
  scheduling, idle and exit timing obligations.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - refresh on cs ras cas low, we high
// - refresh rows from internal counter only
// - banks left precharged idle after refresh
// - self-refresh entry adds cke low
// - dll off on entry, on with reset
// - ignore inputs except cke and a nop or deselect for exit, self-timed refresh
// - internal refresh within tCKE of entry; the core strobes the first one TCKE+1 cycles after entry
module ddrrf_core #(
  parameter int TRFC        = ddrrf_pkg::TRFC_CYC,
  parameter int TCKE        = ddrrf_pkg::TCKE_CYC,
  parameter int SELF_PERIOD = ddrrf_pkg::SELF_TIMER_CYC,
  parameter int DLL_RELOCK  = ddrrf_pkg::DLL_RELOCK_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_ce,
  input  wire ddrrf_pkg::ddrrf_cmd_t    i_cmd,
  input  wire logic [ddrrf_pkg::ROW_W-1:0] i_addr,
  input  wire logic                     i_dll_enable,
  output ddrrf_pkg::ddrrf_stat_t        o_stat,
  output logic                          o_clk_gate
);
  import ddrrf_pkg::*;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  initial begin
    if (TRFC < 1 || TCKE < 1 || SELF_PERIOD <= TCKE || DLL_RELOCK < 1) $error("ddrrf_core: bad timing");
    if (SELF_PERIOD >= (1 << CNT_W) || TRFC >= (1 << CNT_W)) $error("ddrrf_core: count too wide");
  end

  typedef struct packed {
    ddrrf_state_t     fsm;
    ddrrf_stat_t      stat;
    logic             gate;
    logic             first_done;
    logic [CNT_W-1:0] relock;
  } ddrrf_core_st_t;

  ddrrf_core_st_t st;
  ddrrf_core_st_t next_st;

  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_zero;
  logic             cmd_ref;
  logic             cmd_sre;
  logic             cmd_nop;

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  // cke stays high for a plain refresh; cke low marks self-refresh entry
  assign cmd_ref = !i_cmd.cs_n && !i_cmd.ras_n && !i_cmd.cas_n && i_cmd.we_n && i_cmd.cke;
  assign cmd_sre = !i_cmd.cs_n && !i_cmd.ras_n && !i_cmd.cas_n && i_cmd.we_n && !i_cmd.cke;
  assign cmd_nop = i_cmd.cs_n || (i_cmd.ras_n && i_cmd.cas_n && i_cmd.we_n);

  ddrrf_timer #(
    .W (CNT_W)
  ) u_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_load    (tmr_load),
    .i_value   (tmr_value),
    .o_zero    (tmr_zero)
  );

  // ---------------------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st                 = st;
    tmr_load                = 1'b0;
    tmr_value               = '0;
    next_st.stat.row_strobe = 1'b0;
    next_st.stat.dll_rst    = 1'b0;
    if (st.relock != '0) begin
      next_st.relock = st.relock - 1'b1;
    end
    unique case (st.fsm)
      ST_IDLE: begin
        // address bus is never looked at here; the row comes from the counter
        if (cmd_ref) begin
          next_st.fsm             = ST_REFRESH;
          next_st.stat.busy       = 1'b1;
          next_st.stat.banks_idle = 1'b0;
          next_st.stat.row_strobe = 1'b1;
          next_st.stat.row        = st.stat.row + 1'b1;
          tmr_load                = 1'b1;
          tmr_value               = CNT_W'(TRFC);
        end else if (cmd_sre) begin
          next_st.fsm             = ST_SELF;
          next_st.stat.self_ref   = 1'b1;
          next_st.gate            = 1'b1;
          next_st.first_done      = 1'b0;
          if (i_dll_enable) begin
            next_st.stat.dll_on = 1'b0;
          end
          tmr_load                = 1'b1;
          tmr_value               = CNT_W'(TCKE);
        end
      end
      ST_REFRESH: begin
        if (tmr_zero) begin
          next_st.fsm             = ST_IDLE;
          next_st.stat.busy       = 1'b0;
          next_st.stat.banks_idle = 1'b1;
        end
      end
      ST_SELF: begin
        // cke high with a nop or deselect ends sleep; any other command is ignored while asleep
        if (i_cmd.cke && cmd_nop) begin
          next_st.fsm           = ST_EXIT;
          next_st.gate          = 1'b0;
          next_st.stat.self_ref = 1'b0;
          next_st.stat.busy     = 1'b1;
          next_st.relock        = CNT_W'(DLL_RELOCK);
          if (i_dll_enable) begin
            next_st.stat.dll_on  = 1'b1;
            next_st.stat.dll_rst = 1'b1;
          end
          // let an internal refresh in flight finish its tRFC
          if (!tmr_zero || !st.first_done) begin
            tmr_load  = 1'b1;
            tmr_value = CNT_W'(TRFC);
          end
        end else if (tmr_zero) begin
          next_st.stat.row_strobe = 1'b1;
          next_st.stat.row        = st.stat.row + 1'b1;
          next_st.first_done      = 1'b1;
          tmr_load                = 1'b1;
          tmr_value               = CNT_W'(SELF_PERIOD);
        end
      end
      ST_EXIT: begin
        if (tmr_zero) begin
          next_st.fsm       = ST_IDLE;
          next_st.stat.busy = 1'b0;
        end
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st.fsm             <= ST_IDLE;
      st.stat            <= '0;
      st.stat.dll_on     <= 1'b1;
      st.stat.banks_idle <= 1'b1;
      st.stat.row        <= ROW_RST;
      st.gate            <= 1'b0;
      st.first_done      <= 1'b0;
      st.relock          <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_stat     = st.stat;
  assign o_clk_gate = st.gate;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_ref_start;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_IDLE && cmd_ref) |=> (st.fsm == ST_REFRESH && st.stat.row_strobe);
  endproperty
  a_ref_start: assert property (p_ref_start) else $error("refresh not started");

  property p_row_internal;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_IDLE && cmd_ref) |=> (st.stat.row == $past(st.stat.row) + 1'b1);
  endproperty
  a_row_internal: assert property (p_row_internal) else $error("row not from counter");

  property p_idle_after;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.fsm == ST_REFRESH ##1 st.fsm == ST_IDLE) |-> st.stat.banks_idle;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("banks not idle");

  property p_sre_enter;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_IDLE && cmd_sre) |=> (st.stat.self_ref && o_clk_gate);
  endproperty
  a_sre_enter: assert property (p_sre_enter) else $error("self-refresh not entered");

  property p_dll_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_IDLE && cmd_sre && i_dll_enable) |=> !st.stat.dll_on;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("dll not off in self-refresh");

  property p_dll_back;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.fsm == ST_SELF ##1 st.fsm == ST_EXIT && $past(i_dll_enable)) |-> (st.stat.dll_on && st.stat.dll_rst);
  endproperty
  a_dll_back: assert property (p_dll_back) else $error("dll not reset on exit");

  property p_relock_load;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_SELF && i_cmd.cke && cmd_nop) |=> (st.relock == CNT_W'(DLL_RELOCK));
  endproperty
  a_relock_load: assert property (p_relock_load) else $error("dll relock count not started");

  property p_stay_asleep;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ce && st.fsm == ST_SELF && !i_cmd.cke) |=> st.fsm == ST_SELF;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("left self-refresh without cke");

  property p_first_internal;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st.fsm == ST_IDLE ##1 st.fsm == ST_SELF && i_ce) ##1 (st.fsm == ST_SELF && i_ce) [*2]
        |-> ##[0:4] (st.stat.row_strobe || st.fsm != ST_SELF || !i_ce);
  endproperty
  a_first_internal: assert property (p_first_internal) else $error("no refresh after entry");

  c_ref: cover property (@(posedge i_clk) disable iff (i_sys_rst) st.fsm == ST_REFRESH ##1 st.fsm == ST_IDLE);
  c_sre: cover property (@(posedge i_clk) disable iff (i_sys_rst) st.fsm == ST_SELF && st.stat.row_strobe);
  c_srx: cover property (@(posedge i_clk) disable iff (i_sys_rst) st.fsm == ST_EXIT ##1 st.fsm == ST_IDLE);
endmodule

/* File: include/ddrrf_pkg.sv */
/*
  package for the refresh and self-refresh block: command pin layout, state
  enumeration, carrier structs and timing constants.
  assumes a 40 MHz core clock and a single clock domain.
*/
package ddrrf_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int TRFC_NS          = 260;
  localparam int TRFC_CYC         = (TRFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TCKE_NS          = 5;
  localparam int TCKE_CYC_RAW     = (TCKE_NS * 1000) / CLK_PERIOD_PS;
  localparam int TCKE_CYC         = (TCKE_CYC_RAW < 1) ? 1 : TCKE_CYC_RAW;
  localparam int SELF_TIMER_NS    = 7800;
  localparam int SELF_TIMER_CYC   = (SELF_TIMER_NS * 1000) / CLK_PERIOD_PS;
  localparam int DLL_RELOCK_CYC   = 512;

  // ---------------------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------------------
  localparam int ROW_W            = 16;
  localparam int CNT_W            = 16;
  localparam logic [ROW_W-1:0] ROW_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } ddrrf_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REFRESH,
    ST_SELF,
    ST_EXIT
  } ddrrf_state_t;

  typedef struct packed {
    logic             busy;
    logic             self_ref;
    logic             dll_on;
    logic             dll_rst;
    logic             banks_idle;
    logic             row_strobe;
    logic [ROW_W-1:0] row;
  } ddrrf_stat_t;

endpackage

/* File: logic/ddrrf_timer.sv */
/*
  down-counter used for tRFC, tCKE and the self-refresh interval timer.
  assumes load and enable come from the same clock domain as i_clk.
*/
`timescale 1ns/10ps
module ddrrf_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_zero
);
  import ddrrf_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } ddrrf_tmr_t;

  ddrrf_tmr_t st;
  ddrrf_tmr_t next_st;

  initial begin
    if (W < 2) $error("ddrrf_timer: width too small");
  end

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.cnt = i_value;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_zero = (st.cnt == '0);
endmodule

/* File: sim/ddrrf_ctrl_model.sv */
/*
  memory controller model: drives the command pins and address bus.
  assumes commands change only on falling edges of i_clk.
*/
`timescale 1ns/10ps
module ddrrf_ctrl_model
  import ddrrf_pkg::*;
#(
  parameter int TRFC = 3,
  parameter int TXS  = 5
) (
  input  wire logic                      i_clk,
  output ddrrf_pkg::ddrrf_cmd_t          o_cmd,
  output logic [ddrrf_pkg::ROW_W-1:0]    o_addr
);
  // ---------------------------------------------------------------------------
  // command driver
  // ---------------------------------------------------------------------------
  int   gap      = 0;
  int   ref_debt = 0;    // refreshes owed, negative when pulled
  logic asleep   = 1'b0;

  initial begin
    // cke high and idle: a nop on the command pins, address bus at zero
    o_cmd  = 5'h0f;
    o_addr = 16'h0000;
  end

  // one command cycle, then nop with cke held where the command left it
  task automatic issue(input ddrrf_cmd_t c, input logic [ROW_W-1:0] a);
    // a refresh pulled in beyond eight buys nothing, so it goes out as a nop
    if (c == 5'h03 && ref_debt <= -8) c = 5'h0f;
    repeat (gap) @(negedge i_clk);
    @(negedge i_clk);
    o_cmd  = c;
    o_addr = a;
    @(negedge i_clk);
    o_cmd  = {4'h7, c.cke};
    o_addr = ~a; // released bus must not look stable
    gap = (c == 5'h03) ? TRFC + 1 : (c == 5'h0f && c.cke) ? TXS : 0;
    // no interval ticks in so short a run: debt only falls, never while asleep
    if (c == 5'h03 && !asleep) ref_debt = ref_debt - 1;
    asleep = (c == 5'h02) || (asleep && !c.cke);
  endtask
endmodule

/* File: sim/ddrrf_core_tb.sv */
/*
  self-checking bench for the refresh and self-refresh core.
  assumes the controller model drives the command pins; short timing params.
*/
`timescale 1ns/10ps
module ddrrf_core_tb;
  import ddrrf_pkg::*;
  localparam int TRFC = 3;
  localparam int TCKE = 1;
  localparam int SPER = 8;

  typedef struct packed {
    ddrrf_cmd_t       cmd;
    logic [ROW_W-1:0] addr;
    logic             strobe;
  } ddrrf_row_t;

  logic             i_clk;
  logic             i_sys_rst;
  logic             i_ce;
  logic             i_dll_enable;
  ddrrf_cmd_t       i_cmd;
  logic [ROW_W-1:0] i_addr;
  ddrrf_stat_t      o_stat;
  logic             o_clk_gate;
  logic [ROW_W-1:0] exp_row;
  int               miscompares = 0;
  int               checks = 0;
  int               busy_cnt;
  int               cyc;
  ddrrf_row_t       rows [8];

  ddrrf_core #(.TRFC(TRFC), .TCKE(TCKE), .SELF_PERIOD(SPER)) uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_cmd(i_cmd), .i_addr(i_addr),
    .i_dll_enable(i_dll_enable), .o_stat(o_stat), .o_clk_gate(o_clk_gate));

  ddrrf_ctrl_model #(.TRFC(TRFC)) ctrl (.i_clk(i_clk), .o_cmd(i_cmd), .o_addr(i_addr));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    // free-running: never stopped around self-refresh, so always stable at exit
    forever #12.5 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (o_stat.busy === 1'b1) busy_cnt = busy_cnt + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bounded waits: a hang counts as a mismatch
  task automatic wait_idle;
    cyc = 0;
    while (o_stat.busy !== 1'b0 && cyc < 200) begin
      @(negedge i_clk);
      #1;
      cyc++;
    end
    if (cyc >= 200) begin
      chk("busy timeout", 16'h0, 16'h1);
      print_verdict();
    end
  endtask

  task automatic wait_strobe;
    cyc = 0;
    do begin
      @(negedge i_clk);
      #1;
      cyc++;
    end while (o_stat.row_strobe !== 1'b1 && cyc < 200);
    exp_row++;
    if (cyc >= 200) begin
      chk("strobe timeout", 16'h0, 16'h1);
      print_verdict();
    end
  endtask

  task automatic rst_vals;
    chk("busy", 0, o_stat.busy);
    chk("self_ref", 0, o_stat.self_ref);
    chk("dll", 16'h0002, {o_stat.dll_on, o_stat.dll_rst});
    chk("banks_idle", 1, o_stat.banks_idle);
    chk("row", 0, o_stat.row);
    chk("gate", 0, o_clk_gate);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_dll_enable = 1'b1;
    exp_row = 16'h0000;
    rows = '{'{5'h0f, 16'h0000, 1'b0}, '{5'h1f, 16'h0001, 1'b0}, '{5'h07, 16'h00ff, 1'b0},
             '{5'h09, 16'h0f0f, 1'b0}, '{5'h05, 16'h0400, 1'b0}, '{5'h01, 16'h8000, 1'b0},
             '{5'h03, 16'hffff, 1'b1}, '{5'h03, 16'h1234, 1'b1}};
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    rst_vals();
    foreach (rows[k]) begin
      busy_cnt = 0;
      ctrl.issue(rows[k].cmd, rows[k].addr);
      #1;
      exp_row += ROW_W'(rows[k].strobe);
      chk("row_strobe", 16'(rows[k].strobe), o_stat.row_strobe);
      chk("row", exp_row, o_stat.row);
      if (rows[k].strobe) begin
        chk("banks_idle", 0, o_stat.banks_idle);
        wait_idle();
        chk("busy cycles", 16'(TRFC + 1), 16'(busy_cnt));
        chk("banks_idle", 1, o_stat.banks_idle);
      end
    end
    // self-refresh with dll on, stray commands while asleep
    ctrl.issue(5'h02, 16'h5a5a);
    #1;
    chk("sr entry", 16'h000c, {o_stat.self_ref, o_clk_gate, o_stat.dll_on, o_stat.dll_rst});
    wait_strobe();
    chk("first self refresh", 16'(TCKE + 1), 16'(cyc));
    ctrl.issue(5'h02, 16'h0f0f);
    ctrl.issue(5'h00, 16'h7777);
    wait_strobe();
    chk("self period", 16'(SPER + 1), 16'(cyc + 4));
    chk("row", exp_row, o_stat.row);
    i_ce = 1'b0;
    repeat (3 * SPER) @(negedge i_clk);
    #1;
    chk("frozen row", exp_row, o_stat.row);
    i_ce = 1'b1;
    ctrl.issue(5'h0f, 16'h0000);
    #1;
    chk("sr exit", 16'h0003, {o_stat.self_ref, o_clk_gate, o_stat.dll_on, o_stat.dll_rst});
    @(negedge i_clk);
    #1;
    chk("dll_rst", 0, o_stat.dll_rst);
    wait_idle();
    // refresh before re-entry, then a dll-off round trip
    // no write command follows any exit in this run
    ctrl.issue(5'h03, 16'h0000);
    wait_idle();
    i_dll_enable = 1'b0;
    ctrl.issue(5'h02, 16'h0000);
    #1;
    chk("self_ref", 1, o_stat.self_ref);
    ctrl.issue(5'h0f, 16'h0000);
    #1;
    chk("dll_rst off", 0, o_stat.dll_rst);
    wait_idle();
    // reset in mid refresh
    ctrl.issue(5'h03, 16'h0000);
    i_sys_rst = 1'b1;
    #1;
    rst_vals();
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    ctrl.issue(5'h03, 16'h00aa);
    #1;
    chk("row after reset", 16'h0001, o_stat.row);
    print_verdict();
  end
endmodule
